/* shared/tra_defs.svh */
// Register offsets, field positions, reset values and counts of the thermal alarm block
`ifndef TRA_DEFS_SVH
`define TRA_DEFS_SVH

// Word indexes on the bus; byte address is four times the index
`define TRA_IDX_READING    6'h00
`define TRA_IDX_CONFIG     6'h01
`define TRA_IDX_HYST       6'h02
`define TRA_IDX_OVER       6'h03
`define TRA_IDX_STATUS     6'h04

// Configuration byte field positions
`define TRA_CFG_SHDN_BIT   0
`define TRA_CFG_MODE_BIT   1
`define TRA_CFG_POL_BIT    2
`define TRA_CFG_FQ_LO      3
`define TRA_CFG_FQ_HI      4

// Reset values
`define TRA_RST_CONFIG     8'h00
`define TRA_RST_OVER       9'h0A0
`define TRA_RST_HYST       9'h096
`define TRA_RST_READING    11'h000

// Consecutive trips needed per fault count code
`define TRA_FQ_CNT_00      3'h1
`define TRA_FQ_CNT_01      3'h2
`define TRA_FQ_CNT_10      3'h4
`define TRA_FQ_CNT_11      3'h6

// Data layout widths
`define TRA_RES_W          11
`define TRA_LIM_W          9
`define TRA_RES_PAD        5
`define TRA_LIM_PAD        7

`endif

/* shared/tra_pkg.sv */
// Types shared by the thermal alarm block
package tra_pkg;

  typedef struct packed {
    logic [2:0] spare;
    logic [1:0] fault_cnt;
    logic       pol;
    logic       mode;
    logic       shdn;
  } tra_cfg_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    tra_cfg_type cfg;
    logic [10:0] reading;
    logic [8:0]  over;
    logic [8:0]  hyst;
    logic        active;
    logic        wait_low;
    logic        oe;
    logic        conv_en;
    logic        tog_seen;
  } tra_state_type;

  typedef struct packed {
    logic        toggle;
    logic [10:0] data;
  } tra_conv_type;

endpackage

/* hw/tra_sync.sv */
// Two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module tra_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } tra_sync_state_type;

  tra_sync_state_type s_reg;
  tra_sync_state_type s_next;

  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d_i;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.s2;
endmodule

`default_nettype wire

/* hw/tra_fault_queue.sv */
// Counter of consecutive tripping conversions
`include "tra_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tra_fault_queue (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sample_i,
  input  wire logic       trip_i,
  input  wire logic       clear_i,
  input  wire logic [1:0] sel_i,
  output logic            fire_o
);
  typedef struct packed {
    logic [2:0] cnt;
  } tra_fq_state_type;

  tra_fq_state_type s_reg;
  tra_fq_state_type s_next;
  logic [2:0]       need;
  logic [2:0]       cnt_inc;

  always_comb begin
    case (sel_i)
      2'h0:    need = `TRA_FQ_CNT_00;
      2'h1:    need = `TRA_FQ_CNT_01;
      2'h2:    need = `TRA_FQ_CNT_10;
      default: need = `TRA_FQ_CNT_11;
    endcase
    cnt_inc = s_reg.cnt + 3'h1;
    fire_o  = sample_i && trip_i && !clear_i && (cnt_inc >= need);
    s_next  = s_reg;
    if (clear_i) begin
      s_next.cnt = 3'h0;
    end else if (sample_i) begin
      // A clean conversion breaks the run; a fire starts a new one
      if (!trip_i || fire_o) begin
        s_next.cnt = 3'h0;
      end else begin
        s_next.cnt = cnt_inc;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

`default_nettype wire

/* hw/tra_top.sv */
// Temperature result, limit registers and alarm output behind a Wishbone slave
// Overview of operation
// - Reading register loads every conversion end; read-only; two bytes, upper first.
// - Result is 11-bit two's complement, 0.125 degree per step.
// - Result bits 10:3 in upper byte, 2:0 in lower 7:5, rest zero.
// - Two-byte read returns all 16 bits; host collects both bytes.
// - Single-byte read returns upper byte only, whole-degree resolution.
// - Top 9 result bits give 0.5 degree value in limit format.
// - Both limit registers read/write, 9-bit two's complement, 0.5 degree.
// - Limit bits 8:1 in upper byte, bit 0 in lower bit 7, rest zero.
// - After each conversion, compare with both limits and update alarm.
// - Comparison uses only the 9 most significant result bits.
// - Alarm pin is open drain: pulls low or releases.
// - Config bit 2 sets alarm active level high when 1; resets 0.
// - Config bit 1 selects latched mode when 1, comparator when 0.
// - Comparator: assert above overheat limit, release below hysteresis limit.
// - Comparator: reads and shutdown leave alarm unchanged.
// - Latched: assert on either limit crossing, held until any register read.
// - Alarm needs 1, 2, 4 or 6 consecutive tripping conversions.
// - Shutdown stops conversions, keeps register access, clears latched alarm.
// - Reset values: overheat limit 80 degrees, hysteresis limit 75 degrees.
`include "tra_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tra_top (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Classic Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Converter side, asynchronous
  input  wire tra_pkg::tra_conv_type conv_i,
  output logic                    conv_en_o,
  // Open-drain alarm pin
  input  wire logic               alarm_i,
  output logic                    alarm_o,
  output logic                    alarm_oe_o
);
  import tra_pkg::*;

  tra_state_type s_reg;
  tra_state_type s_next;
  tra_conv_type  conv_sync;
  tra_cfg_type   wr_cfg;
  logic          line_sync;
  logic          req;
  logic          rd_hit;
  logic          cfg_wr;
  logic [5:0]    idx;
  logic          conv_evt;
  logic [10:0]   new_res;
  logic [8:0]    res9;
  logic          above;
  logic          below;
  logic          trip;
  logic          fire;

  // Result word and toggle cross together; converter holds data until next toggle
  tra_sync #(
    .W ($bits(tra_conv_type))
  ) u_conv_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (conv_i),
    .q_o   (conv_sync)
  );

  tra_sync #(
    .W (1)
  ) u_line_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (alarm_i),
    .q_o   (line_sync)
  );

  tra_fault_queue u_fq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .sample_i (conv_evt),
    .trip_i   (trip),
    .clear_i  (cfg_wr),
    .sel_i    (s_reg.cfg.fault_cnt),
    .fire_o   (fire)
  );

  always_comb begin
    idx    = wb_adr_i[7:2];
    req    = wb_cyc_i && wb_stb_i && !s_reg.ack;
    rd_hit = req && !wb_we_i && (idx <= `TRA_IDX_STATUS);
    cfg_wr = req && wb_we_i && (idx == `TRA_IDX_CONFIG) && wb_sel_i[0];
    wr_cfg = wb_dat_i[7:0];

    // Conversions are ignored while shut down
    conv_evt = (conv_sync.toggle != s_reg.tog_seen) && !s_reg.cfg.shdn;
    new_res  = conv_sync.data;
    // Only the top 9 bits meet the limits, signed
    res9  = new_res[10:2];
    above = $signed(res9) > $signed(s_reg.over);
    below = $signed(res9) < $signed(s_reg.hyst);
    // Which crossing counts depends on mode and present phase
    if (s_reg.cfg.mode) begin
      trip = s_reg.wait_low ? below : above;
    end else begin
      trip = s_reg.active ? below : above;
    end

    s_next          = s_reg;
    s_next.ack      = req;
    s_next.tog_seen = conv_sync.toggle;

    if (conv_evt) begin
      s_next.reading = new_res;
    end

    // Alarm update after each conversion through the fault queue
    if (fire) begin
      if (s_reg.cfg.mode) begin
        s_next.active   = 1'b1;
        s_next.wait_low = !s_reg.wait_low;
      end else begin
        s_next.active = !s_reg.active;
      end
    end else if (rd_hit && s_reg.cfg.mode) begin
      // Any register read clears a latched alarm; a same-cycle fire wins
      s_next.active = 1'b0;
    end

    if (req) begin
      if (wb_we_i) begin
        case (idx)
          `TRA_IDX_CONFIG: begin
            if (wb_sel_i[0]) begin
              s_next.cfg = wr_cfg;
              if (wr_cfg.mode != s_reg.cfg.mode) begin
                // Mode swap starts from a quiet alarm
                s_next.active   = 1'b0;
                s_next.wait_low = 1'b0;
              end else if (wr_cfg.shdn && !s_reg.cfg.shdn && wr_cfg.mode) begin
                s_next.active = 1'b0;
              end
            end
          end
          `TRA_IDX_HYST: begin
            if (wb_sel_i[1]) begin
              s_next.hyst[8:1] = wb_dat_i[15:8];
            end
            if (wb_sel_i[0]) begin
              s_next.hyst[0] = wb_dat_i[7];
            end
          end
          `TRA_IDX_OVER: begin
            if (wb_sel_i[1]) begin
              s_next.over[8:1] = wb_dat_i[15:8];
            end
            if (wb_sel_i[0]) begin
              s_next.over[0] = wb_dat_i[7];
            end
          end
          default: begin
            s_next.rdata = s_reg.rdata;
          end
        endcase
        s_next.rdata = 32'h0000_0000;
      end else begin
        case (idx)
          // Upper byte in 15:8 so a one-lane read gives whole degrees
          `TRA_IDX_READING: s_next.rdata = {16'h0000, s_reg.reading, `TRA_RES_PAD'h00};
          `TRA_IDX_CONFIG:  s_next.rdata = {24'h00_0000, s_reg.cfg};
          `TRA_IDX_HYST:    s_next.rdata = {16'h0000, s_reg.hyst, `TRA_LIM_PAD'h00};
          `TRA_IDX_OVER:    s_next.rdata = {16'h0000, s_reg.over, `TRA_LIM_PAD'h00};
          `TRA_IDX_STATUS:  s_next.rdata = {30'h0000_0000, line_sync, s_reg.active};
          default:          s_next.rdata = 32'h0000_0000;
        endcase
      end
    end else begin
      s_next.rdata = 32'h0000_0000;
    end

    // Pull low when the pin must show low
    s_next.oe      = s_next.active ^ s_next.cfg.pol;
    s_next.conv_en = !s_next.cfg.shdn;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg          <= '0;
      s_reg.cfg      <= `TRA_RST_CONFIG;
      s_reg.over     <= `TRA_RST_OVER;
      s_reg.hyst     <= `TRA_RST_HYST;
      s_reg.reading  <= `TRA_RST_READING;
      s_reg.conv_en  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o   = s_reg.rdata;
  assign wb_ack_o   = s_reg.ack;
  assign conv_en_o  = s_reg.conv_en;
  assign alarm_o    = 1'b0;
  assign alarm_oe_o = s_reg.oe;
endmodule

`default_nettype wire

/* bench/tra_monitor.sv */
// Bus, pin and reset checks on the thermal alarm block
`timescale 1ns/1ps
`default_nettype none
module tra_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        conv_en_o,
  input wire logic        alarm_o,
  input wire logic        alarm_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_res_s;
    req_s ##0 (!wb_we_i && wb_adr_i[7:2] == 6'h00);
  endsequence
  sequence rd_lim_s;
    req_s ##0 (!wb_we_i && wb_adr_i[7:2] inside {6'h02, 6'h03});
  endsequence
  ack_latency_a: assert property (req_s |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  result_pad_a: assert property (rd_res_s |=> wb_dat_o[4:0] == 5'h0 && wb_dat_o[31:16] == 16'h0)
    else $error("result padding not zero");
  limit_pad_a: assert property (rd_lim_s |=> wb_dat_o[6:0] == 7'h0 && wb_dat_o[31:16] == 16'h0)
    else $error("limit padding not zero");
  pin_drive_a: assert property (alarm_o == 1'b0)
    else $error("alarm pin driven high");
  reset_state_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !alarm_oe_o && conv_en_o)
    else $error("wrong state after reset");
  shutdown_cause_a: assert property ($changed(conv_en_o) |-> $past(wb_stb_i && wb_we_i))
    else $error("conversion enable moved without write");
endmodule
bind tra_top tra_monitor tra_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .conv_en_o(conv_en_o), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o));
`default_nettype wire

/* bench/tra_conv_model.sv */
// Converter stand-in that hands over results by toggling
`timescale 1ns/1ps
`default_nettype none
module tra_conv_model (
  input  wire logic              clk_i,
  input  wire logic              en_i,
  output var tra_pkg::tra_conv_type conv_o
);
  import tra_pkg::*;
  initial conv_o = '0;
  task automatic convert(input logic [10:0] v);
    @(posedge clk_i);
    if (en_i) begin
      conv_o.data <= v;
      @(posedge clk_i);
      conv_o.toggle <= ~conv_o.toggle;
    end
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench of the thermal alarm block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tra_pkg::*;
  logic         clk_i = 0;
  logic         rst_i = 1;
  logic         cyc = 0;
  logic         stb = 0;
  logic         we = 0;
  logic [7:0]   adr = 0;
  logic [3:0]   sel = 0;
  logic [31:0]  wdat = 0;
  logic [31:0]  rdat;
  logic [31:0]  q;
  logic         ack;
  logic         en;
  logic         ao;
  logic         oe;
  tra_conv_type conv;
  int           num_errors = 0;
  int           comparisons = 0;
  int           cycles = 0;
  // Pull-up holds the line high when released
  wire          line = oe ? 1'b0 : 1'b1;
  always #5 clk_i = ~clk_i;
  tra_conv_model tra_conv_model_i (.clk_i(clk_i), .en_i(en), .conv_o(conv));
  tra_top tra_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .conv_i(conv), .conv_en_o(en), .alarm_i(line), .alarm_o(ao),
    .alarm_oe_o(oe));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0);
    chk($sformatf("register %h", a), e, q);
  endtask
  task automatic alarm(input logic e);
    repeat (2) @(posedge clk_i);
    chk("alarm drive", {31'h0, e}, {31'h0, oe});
  endtask
  // Note's latency is three cycles; six leave margin
  task automatic temp(input logic [10:0] v, input logic e);
    tra_conv_model_i.convert(v);
    repeat (6) @(posedge clk_i);
    alarm(e);
  endtask
  task automatic t_regs();
    rd(8'h08, 32'h4B00);
    rd(8'h0C, 32'h5000);
    rd(8'h04, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h2);
    rd(8'h14, 32'h0);
    xfer(1, 8'h0C, 32'h5080);
    xfer(1, 8'h08, 32'h4BFF);
    xfer(1, 8'h00, 32'h1234);
    rd(8'h0C, 32'h5080);
    rd(8'h08, 32'h4B80);
    rd(8'h00, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_comp();
    temp(11'h287, 0);
    rd(8'h00, 32'h50E0);
    temp(11'h288, 1);
    rd(8'h00, 32'h5100);
    alarm(1);
    temp(11'h268, 1);
    temp(11'h7F8, 0);
    $display("test comparator done");
  endtask
  task automatic t_latch();
    xfer(1, 8'h04, 32'h2);
    temp(11'h288, 1);
    rd(8'h00, 32'h5100);
    alarm(0);
    temp(11'h288, 0);
    temp(11'h250, 1);
    xfer(1, 8'h04, 32'h3);
    alarm(0);
    chk("conversion enable", 32'h0, {31'h0, en});
    rd(8'h04, 32'h3);
    xfer(1, 8'h04, 32'h0);
    $display("test latched done");
  endtask
  task automatic t_fault();
    xfer(1, 8'h04, 32'h1C);
    alarm(1);
    for (int i = 0; i < 6; i++) begin
      temp(11'h288, i < 5);
    end
    $display("test fault count done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    t_regs();
    t_comp();
    t_latch();
    t_fault();
    results();
  end
endmodule
`default_nettype wire
